// file: rtl/sric_pkg.sv
// Constants for the standby, reset and interrupt controller
package sric_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned POR_HOLD_MS    = 300;
  localparam int unsigned POR_HOLD_CYC   = POR_HOLD_MS * CLK_PER_MS;
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_PER_MS;
  localparam int unsigned EXIT_DELAY_MS  = 50;
  localparam int unsigned EXIT_DELAY_CYC = EXIT_DELAY_MS * CLK_PER_MS;
  // ==========================================================
  // Register map
  // ==========================================================
  localparam int         ADDR_W       = 4;
  localparam logic [3:0] OFS_STATUS   = 4'h0;
  localparam logic [3:0] OFS_CLEAR    = 4'h4;
  localparam int         ST_STBY_IRQ  = 0;
  localparam int         ST_KBD_FLAG  = 1;
  localparam int         ST_STANDBY   = 2;
  localparam int         ST_IRQ_EN    = 3;
  localparam int         ST_CPU_RST   = 4;
  localparam int         ST_GPIB_RST  = 5;
  localparam int         CLR_STBY_IRQ = 0;
  localparam int         CLR_KBD      = 1;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;
  // ==========================================================
  // Pin inputs
  // ==========================================================
  localparam int         NPINS     = 6;
  localparam int         PIN_PWR   = 0;
  localparam int         PIN_KEY   = 1;
  localparam int         PIN_SLEEP = 2;
  localparam int         PIN_KRDY  = 3;
  localparam int         PIN_MEAS  = 4;
  localparam int         PIN_GPIB  = 5;
  localparam logic [5:0] PIN_RST   = 6'h06;
endpackage

// file: rtl/sric_debounce.sv
// Key debouncer: output follows input once it has held steady
`timescale 1ns/1ps
module sric_debounce #(
  parameter int unsigned CNT = 16
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic [31:0] cnt_ff;

  // ==========================================================
  // Stability counter
  // ==========================================================
  // Any bounce restarts the count, so only a settled level passes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 32'h0;
      dout   <= 1'b1;
    end
    else if (din == dout)
    begin
      cnt_ff <= 32'h0;
    end
    else if (cnt_ff >= CNT - 1)
    begin
      cnt_ff <= 32'h0;
      dout   <= din;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
endmodule

// file: rtl/sric_top.sv
// Standby, reset and interrupt controller with AXI4-Lite status port
//
// Summary of operation
// - Hold reset about 300 ms after power arrives, then release.
// - Processor and GPIB resets both come from the same power-on timing.
// - Standby supply drop restarts the full reset interval.
// - Debounced falling standby key edge sets the standby interrupt latch.
// - Standby interrupt latch set drives processor interrupt low.
// - Standby interrupt flag is readable by the processor.
// - Each setting of the standby interrupt latch toggles standby state.
// - In standby: indicator lit, other interrupt sources blocked.
// - In standby: shutdown asserted to all supplies but standby ones.
// - After sleep entry only the standby key leaves standby.
// - Key-ready rising edge sets keyboard latch: flag and request.
// - Keyboard, measurement and GPIB requests ORed into one request.
// - Combined request reaches processor only outside standby.
// - Standby interrupt bypasses standby gating on entry; on exit it waits out the exit delay.
// - In standby interrupts disabled and GPIB reset held.
// - After leaving standby, delay before interrupts and GPIB release.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module sric_top #(
  parameter int unsigned POR_CYC  = sric_pkg::POR_HOLD_CYC,
  parameter int unsigned DEB_CYC  = sric_pkg::DEBOUNCE_CYC,
  parameter int unsigned EXIT_CYC = sric_pkg::EXIT_DELAY_CYC
)(
  input  wire logic                        CLK,
  input  wire logic                        RESETN,
  input  wire logic                        STBY_SUPPLY_OK,
  input  wire logic                        STBY_KEY_N,
  input  wire logic                        SLEEP_REQ_N,
  input  wire logic                        KEY_READY,
  input  wire logic                        MEASURE_UNIT_IRQ,
  input  wire logic                        GPIB_IRQ,
  output logic                             CPU_RESET_N,
  output logic                             GPIB_RESET_N,
  output logic                             CPU_IRQ_N,
  output logic                             STANDBY_LED,
  output logic                             SUPPLY_SHUTDOWN,
  input  wire logic [sric_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  output logic [1:0]                       S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  input  wire logic [sric_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  output logic [31:0]                      S_AXI_RDATA,
  output logic [1:0]                       S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;
  wire  [5:0] pins = {GPIB_IRQ, MEASURE_UNIT_IRQ, KEY_READY,
                      SLEEP_REQ_N, STBY_KEY_N, STBY_SUPPLY_OK};
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      pin_meta_ff <= sric_pkg::PIN_RST;
      pin_sync_ff <= sric_pkg::PIN_RST;
    end
    else
    begin
      pin_meta_ff <= pins;
      pin_sync_ff <= pin_meta_ff;
    end
  end
  wire supply_ok = pin_sync_ff[sric_pkg::PIN_PWR];
  wire sleep_n   = pin_sync_ff[sric_pkg::PIN_SLEEP];
  wire krdy      = pin_sync_ff[sric_pkg::PIN_KRDY];
  // ==========================================================
  // Power-on and power-fail reset timer
  // ==========================================================
  logic [31:0] por_cnt_ff;
  logic [31:0] nxt_por_cnt;
  wire         por_done = (por_cnt_ff >= POR_CYC);
  // A dip restarts the whole hold, so a quick return still gets a full reset
  assign nxt_por_cnt = !supply_ok ? 32'h0 :
                       por_done   ? por_cnt_ff :
                                    por_cnt_ff + 32'h1;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      por_cnt_ff <= 32'h0;
    else
      por_cnt_ff <= nxt_por_cnt;
  end
  // ==========================================================
  // Standby key, sleep request and key-ready edges
  // ==========================================================
  logic key_n_db;
  logic key_prev_ff;
  logic sleep_prev_ff;
  logic krdy_prev_ff;
  sric_debounce #(
    .CNT (DEB_CYC)
  ) u_key_db (
    .clk   (CLK),
    .rst_n (RESETN),
    .din   (pin_sync_ff[sric_pkg::PIN_KEY]),
    .dout  (key_n_db)
  );

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      key_prev_ff   <= 1'b1;
      sleep_prev_ff <= 1'b1;
      krdy_prev_ff  <= 1'b0;
    end
    else
    begin
      key_prev_ff   <= key_n_db;
      sleep_prev_ff <= sleep_n;
      krdy_prev_ff  <= krdy;
    end
  end
  logic standby_ff;
  logic stby_irq_ff;
  logic kbd_ff;
  logic clr_stby;
  logic clr_kbd;
  wire key_press = key_prev_ff & ~key_n_db;
  // Sleep only puts the unit to sleep; waking needs the key
  wire sleep_req = sleep_prev_ff & ~sleep_n & ~standby_ff;
  wire stby_set  = (key_press | sleep_req) & por_done;
  wire stby_rise = stby_set & ~stby_irq_ff;
  wire krdy_rise = krdy & ~krdy_prev_ff;

  // ==========================================================
  // Interrupt and standby latches
  // ==========================================================
  logic nxt_stby_irq;
  logic nxt_kbd;
  logic nxt_standby;
  // Set beats clear when both land in one cycle
  assign nxt_stby_irq = stby_set | (stby_irq_ff & ~clr_stby);
  assign nxt_kbd      = krdy_rise | (kbd_ff & ~clr_kbd);
  assign nxt_standby  = stby_rise ? ~standby_ff : standby_ff;

  always_ff @(posedge CLK)
  begin
    if (!RESETN || !por_done)
    begin
      stby_irq_ff <= 1'b0;
      kbd_ff      <= 1'b0;
      standby_ff  <= 1'b0;
    end
    else
    begin
      stby_irq_ff <= nxt_stby_irq;
      kbd_ff      <= nxt_kbd;
      standby_ff  <= nxt_standby;
    end
  end
  // ==========================================================
  // Standby exit delay
  // ==========================================================
  logic [31:0] exit_cnt_ff;
  wire         exit_done = (exit_cnt_ff >= EXIT_CYC);
  wire         exit_wait = ~standby_ff & ~exit_done;
  wire         irq_en    = ~standby_ff & exit_done;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      exit_cnt_ff <= 32'(EXIT_CYC);
    else if (standby_ff)
      exit_cnt_ff <= 32'h0;
    else if (!exit_done)
      exit_cnt_ff <= exit_cnt_ff + 32'h1;
  end

  // ==========================================================
  // Interrupt combining and outputs
  // ==========================================================
  wire comb_req = kbd_ff | pin_sync_ff[sric_pkg::PIN_MEAS]
                         | pin_sync_ff[sric_pkg::PIN_GPIB];
  // Standby request bypasses standby gating but waits out the exit delay
  wire irq_on   = (stby_irq_ff & ~exit_wait)
                | (comb_req & irq_en);

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      CPU_RESET_N     <= 1'b0;
      GPIB_RESET_N    <= 1'b0;
      CPU_IRQ_N       <= 1'b1;
      STANDBY_LED     <= 1'b0;
      SUPPLY_SHUTDOWN <= 1'b0;
    end
    else
    begin
      CPU_RESET_N     <= por_done;
      GPIB_RESET_N    <= por_done & irq_en;
      CPU_IRQ_N       <= ~irq_on;
      STANDBY_LED     <= standby_ff;
      SUPPLY_SHUTDOWN <= standby_ff;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  logic                        aw_full_ff;
  logic                        w_full_ff;
  logic [sric_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0]                 wdata_ff;
  logic                        wstrb0_ff;
  wire aw_hs  = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs   = S_AXI_WVALID & S_AXI_WREADY;
  wire wr_go  = aw_full_ff & w_full_ff & ~S_AXI_BVALID;
  wire wr_hit = (awaddr_ff == sric_pkg::OFS_CLEAR)
              | (awaddr_ff == sric_pkg::OFS_STATUS);
  wire wr_clr = wr_go & (awaddr_ff == sric_pkg::OFS_CLEAR) & wstrb0_ff;
  assign clr_stby = wr_clr & wdata_ff[sric_pkg::CLR_STBY_IRQ];
  assign clr_kbd  = wr_clr & wdata_ff[sric_pkg::CLR_KBD];

  wire nxt_aw_full = aw_hs | (aw_full_ff & ~wr_go);
  wire nxt_w_full  = w_hs | (w_full_ff & ~wr_go);
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      aw_full_ff    <= 1'b0;
      w_full_ff     <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= 32'h0;
      wstrb0_ff     <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= sric_pkg::RESP_OKAY;
    end
    else
    begin
      aw_full_ff    <= nxt_aw_full;
      w_full_ff     <= nxt_w_full;
      S_AXI_AWREADY <= ~nxt_aw_full;
      S_AXI_WREADY  <= ~nxt_w_full;
      if (aw_hs)
        awaddr_ff <= S_AXI_AWADDR;
      if (w_hs)
      begin
        wdata_ff  <= S_AXI_WDATA;
        wstrb0_ff <= S_AXI_WSTRB[0];
      end
      if (wr_go)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? sric_pkg::RESP_OKAY : sric_pkg::RESP_DECERR;
      end
      else if (S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  logic [31:0] status_word;
  always_comb
  begin
    status_word = 32'h0;
    status_word[sric_pkg::ST_STBY_IRQ] = stby_irq_ff;
    status_word[sric_pkg::ST_KBD_FLAG] = kbd_ff;
    status_word[sric_pkg::ST_STANDBY]  = standby_ff;
    status_word[sric_pkg::ST_IRQ_EN]   = irq_en;
    status_word[sric_pkg::ST_CPU_RST]  = ~por_done;
    status_word[sric_pkg::ST_GPIB_RST] = ~(por_done & irq_en);
  end
  wire ar_hs   = S_AXI_ARVALID & S_AXI_ARREADY;
  wire rd_stat = (S_AXI_ARADDR == sric_pkg::OFS_STATUS);
  wire rd_clr  = (S_AXI_ARADDR == sric_pkg::OFS_CLEAR);
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= sric_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_stat ? status_word : 32'h0;
      S_AXI_RRESP   <= (rd_stat | rd_clr) ? sric_pkg::RESP_OKAY
                                          : sric_pkg::RESP_DECERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
    else if (!S_AXI_RVALID)
      S_AXI_ARREADY <= 1'b1;
  end
  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_leave;
    standby_ff ##1 !standby_ff;
  endsequence
  property p_por_release;
    $rose(CPU_RESET_N) |-> $past(por_cnt_ff) == POR_CYC;
  endproperty
  a_por_release: assert property (p_por_release) else $error("Reset released early");
  property p_rst_pair;
    !CPU_RESET_N |-> !GPIB_RESET_N;
  endproperty
  a_rst_pair: assert property (p_rst_pair) else $error("GPIB out of reset first");
  property p_supply_drop;
    $fell(supply_ok) |-> ##2 !CPU_RESET_N;
  endproperty
  a_supply_drop: assert property (p_supply_drop) else $error("Drop gave no reset");
  property p_key_sets;
    key_press && por_done |=> stby_irq_ff;
  endproperty
  a_key_sets: assert property (p_key_sets) else $error("Key did not set latch");
  property p_stby_irq;
    stby_irq_ff && !exit_wait |=> !CPU_IRQ_N;
  endproperty
  a_stby_irq: assert property (p_stby_irq) else $error("Standby irq not driven");
  property p_toggle;
    stby_rise && por_done |=> standby_ff != $past(standby_ff);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Standby did not toggle");
  property p_indicators;
    standby_ff |=> STANDBY_LED && SUPPLY_SHUTDOWN;
  endproperty
  a_indicators: assert property (p_indicators) else $error("Standby outputs missing");
  property p_gate;
    standby_ff && !stby_irq_ff |=> CPU_IRQ_N && !GPIB_RESET_N;
  endproperty
  a_gate: assert property (p_gate) else $error("Interrupt passed in standby");
  property p_exit_delay;
    s_leave |=> !GPIB_RESET_N [*2];
  endproperty
  a_exit_delay: assert property (p_exit_delay) else $error("GPIB released early");
  // Latched keyboard request must pull the pin low once interrupts are enabled
  property p_kbd;
    krdy_rise && por_done |=> kbd_ff ##1 (!CPU_IRQ_N || !$past(irq_en));
  endproperty
  a_kbd: assert property (p_kbd) else $error("Keyboard latch not set");
endmodule

// file: tb/sric_cpu_model.sv
// Processor side of the status port: AXI4-Lite master tasks
`timescale 1ns/1ps
module sric_cpu_model (
  input  wire logic        clk,
  output logic [3:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [3:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // ==========================================================
  // Write: address and data offered together, each dropped when taken
  // ==========================================================
  // Latch clears are write-one pulses, so the handler ends with this write
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_go;
    logic w_go;
    aw_go = 1'b1;
    w_go  = 1'b1;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (aw_go || w_go)
    begin
      @(posedge clk);
      if (aw_go && awready === 1'b1)
      begin
        aw_go = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_go && wready === 1'b1)
      begin
        w_go = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do
      @(posedge clk);
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // ==========================================================
  // Read
  // ==========================================================
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
      @(posedge clk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// file: tb/standby_reset_irq_control_test.sv
// Self-checking bench for the standby, reset and interrupt controller
`timescale 1ns/1ps
module standby_reset_irq_control_test;
  localparam int unsigned POR  = 50;
  localparam int unsigned DEB  = 4;
  localparam int unsigned EXIT = 20;

  logic        clk       = 1'b0;
  logic        resetn    = 1'b0;
  logic        supply_ok = 1'b1;
  logic        key_n     = 1'b1;
  logic        sleep_n   = 1'b1;
  logic        key_ready = 1'b0;
  logic        meas_irq  = 1'b0;
  logic        gpib_irq  = 1'b0;
  wire  [4:0]  outs;
  logic [3:0]  aw_addr, ar_addr, w_strb;
  logic [31:0] w_data, r_data, d;
  logic [1:0]  b_resp, r_resp, r;
  logic        aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
  logic        ar_valid, ar_ready, r_valid, r_ready;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  // Rows: measurement request, GPIB request, expected interrupt pin
  logic [2:0]  tbl [4] = '{3'h1, 3'h4, 3'h2, 3'h6};

  always #4 clk = ~clk;

  // ==========================================================
  // Design and processor model
  // ==========================================================
  sric_top #(.POR_CYC(POR), .DEB_CYC(DEB), .EXIT_CYC(EXIT)) DUT (
    .CLK(clk), .RESETN(resetn), .STBY_SUPPLY_OK(supply_ok), .STBY_KEY_N(key_n),
    .SLEEP_REQ_N(sleep_n), .KEY_READY(key_ready), .MEASURE_UNIT_IRQ(meas_irq),
    .GPIB_IRQ(gpib_irq), .CPU_RESET_N(outs[4]), .GPIB_RESET_N(outs[3]),
    .CPU_IRQ_N(outs[2]), .STANDBY_LED(outs[1]), .SUPPLY_SHUTDOWN(outs[0]),
    .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
    .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid),
    .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
    .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready));

  sric_cpu_model cpu (
    .clk(clk), .awaddr(aw_addr), .awvalid(aw_valid), .awready(aw_ready),
    .wdata(w_data), .wstrb(w_strb), .wvalid(w_valid), .wready(w_ready),
    .bresp(b_resp), .bvalid(b_valid), .bready(b_ready), .araddr(ar_addr),
    .arvalid(ar_valid), .arready(ar_ready), .rdata(r_data), .rresp(r_resp),
    .rvalid(r_valid), .rready(r_ready));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Key held well past the debounce count, then released
  task automatic press();
    key_n <= 1'b0;
    cyc(DEB + 8);
    key_n <= 1'b1;
  endtask

  // Status bits 2:0 (standby state, keyboard flag, standby flag) with OKAY
  task automatic stat(input logic [2:0] exp);
    cpu.rd(4'h0, d, r);
    chk({r, d[2:0]}, {2'h0, exp});
  endtask

  // A hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      close_out();
    end
  end

  // ==========================================================
  // Sequence
  // ==========================================================
  initial
  begin
    cyc(7);
    chk(outs, 5'h04);
    cyc(1);
    resetn <= 1'b1;
    cyc(POR - 20);
    chk(outs, 5'h04);
    cyc(40);
    chk(outs, 5'h1c);
    cpu.rd(4'h8, d, r);
    chk({d[29:0], r}, 32'h3);
    cpu.wr(4'hc, 32'h3, r);
    chk(r, 2'h3);
    stat(3'h0);
    for (int i = 0; i < 4; i++)
    begin
      meas_irq <= tbl[i][2];
      gpib_irq <= tbl[i][1];
      cyc(6);
      chk(outs[2], tbl[i][0]);
    end
    meas_irq <= 1'b0;
    gpib_irq <= 1'b0;
    key_ready <= 1'b1;
    cyc(6);
    chk(outs[2], 1'h0);
    stat(3'h2);
    key_ready <= 1'b0;
    cpu.wr(4'h4, 32'h2, r);
    cyc(4);
    chk(outs[2], 1'h1);
    // Entry: standby interrupt reaches the processor despite the gating
    press();
    chk(outs, 5'h13);
    stat(3'h5);
    meas_irq <= 1'b1;
    cpu.wr(4'h4, 32'h1, r);
    cyc(4);
    chk(outs, 5'h17);
    stat(3'h4);
    // Exit: interrupts and GPIB release wait out the exit delay
    press();
    chk(outs, 5'h14);
    cyc(EXIT + 10);
    chk(outs, 5'h18);
    cpu.wr(4'h4, 32'h1, r);
    cyc(4);
    chk(outs[2], 1'h0);
    meas_irq <= 1'b0;
    cyc(4);
    chk(outs, 5'h1c);
    // Battery pack asks for sleep
    sleep_n <= 1'b0;
    cyc(8);
    chk(outs[1:0], 2'h3);
    sleep_n <= 1'b1;
    cyc(8);
    chk(outs[1:0], 2'h3);
    cpu.wr(4'h4, 32'h1, r);
    press();
    chk(outs[1:0], 2'h0);
    cyc(EXIT + 10);
    cpu.wr(4'h4, 32'h1, r);
    cyc(4);
    chk(outs, 5'h1c);
    // Short supply drop must still give the whole hold time
    supply_ok <= 1'b0;
    cyc(4);
    supply_ok <= 1'b1;
    cyc(1);
    chk(outs[4:3], 2'h0);
    cyc(POR - 10);
    chk(outs[4:3], 2'h0);
    cyc(20);
    chk(outs[4:3], 2'h3);
    resetn <= 1'b0;
    cyc(3);
    chk(outs, 5'h04);
    resetn <= 1'b1;
    cyc(3);
    chk(outs, 5'h04);
    stat(3'h0);
    close_out();
  end
endmodule
